// *** hdl/ctm_pkg.sv ***
// Package of the compact timer: register map, field layout, modes and clock selects.
// Assumes a 32-bit APB master; each register takes one aligned word, data in the low byte.
package ctm_pkg;

  localparam int CTM_CNT_W = 10;
  localparam int CTM_P_W = 3;

  // Register byte addresses.
  localparam logic [7:0] CTM_OFS_CTRL0 = 8'h00;
  localparam logic [7:0] CTM_OFS_CTRL1 = 8'h04;
  localparam logic [7:0] CTM_OFS_CNT_LO = 8'h08;
  localparam logic [7:0] CTM_OFS_CNT_HI = 8'h0C;
  localparam logic [7:0] CTM_OFS_CMPA_LO = 8'h10;
  localparam logic [7:0] CTM_OFS_CMPA_HI = 8'h14;
  localparam logic [7:0] CTM_OFS_FLAGS = 8'h18;

  // Control register zero field positions.
  localparam int CTM_C0_ON = 3;
  localparam int CTM_C0_CK_LSB = 4;

  // Flag register bit positions; write one to clear.
  localparam int CTM_FLAG_A = 0;
  localparam int CTM_FLAG_P = 1;

  localparam logic [7:0] CTM_RST_BYTE = 8'h00;
  localparam logic [CTM_CNT_W-1:0] CTM_CNT_MAX = 10'h3FF;
  localparam logic [CTM_P_W-1:0] CTM_P_ZERO = 3'h0;

  // Divider ratios for internal clock selects.
  localparam int CTM_DIV_SYS4 = 4;
  localparam int CTM_DIV_H16 = 16;
  localparam int CTM_DIV_H64 = 64;

  typedef enum logic [1:0] {
    CTM_MODE_CMP = 2'h0,
    CTM_MODE_UNDEF = 2'h1,
    CTM_MODE_PWM = 2'h2,
    CTM_MODE_TMR = 2'h3
  } ctm_mode_type;

  typedef enum logic [2:0] {
    CTM_CK_SYS4 = 3'h0,
    CTM_CK_SYS = 3'h1,
    CTM_CK_H16 = 3'h2,
    CTM_CK_H64 = 3'h3,
    CTM_CK_TBC0 = 3'h4,
    CTM_CK_TBC1 = 3'h5,
    CTM_CK_EXTR = 3'h6,
    CTM_CK_EXTF = 3'h7
  } ctm_clk_sel_type;

  // Control register one layout, bit 7 first.
  typedef struct packed {
    ctm_mode_type op_mode;
    logic [1:0] pin_action;
    logic pin_initial_level;
    logic pin_invert;
    logic period_duty_swap;
    logic clear_source_sel;
  } ctm_ctrl1_type;

  // APB request bundle.
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } ctm_apb_req_type;

  // External clock and time-base inputs.
  typedef struct packed {
    logic fh;
    logic ftbc;
    logic ext_clk;
  } ctm_clk_in_type;

endpackage

// *** hdl/ctm_timer.sv ***
// Compact 10-bit timer with compare-match, timer/counter and edge-aligned PWM modes.
// Assumes all inputs synchronous to MCLK; fH, fTBC and the external pin are sampled levels.
//
// Our own choices: the register addresses and the APB slave port.
`timescale 1ns/1ps
`default_nettype none

module ctm_timer
  import ctm_pkg::*;
(
  // Clock and reset.
  input wire logic MCLK,
  input wire logic RSTN,
  // APB slave.
  input wire ctm_pkg::ctm_apb_req_type APB_REQ,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Count clock sources.
  input wire ctm_pkg::ctm_clk_in_type CLK_IN,
  // Timer output pin and flags.
  output logic TMR_OUT,
  output logic MATCH_A_FLAG,
  output logic MATCH_P_FLAG
);
  import ctm_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Registers.
  logic [7:0] ctrl0_q;
  ctm_ctrl1_type ctrl1_q;
  logic [7:0] cmpa_lo_q;
  logic [1:0] cmpa_hi_q;
  logic [CTM_CNT_W-1:0] cnt_q;
  logic [CTM_CNT_W-1:0] cnt_nx;
  logic on_prev_q;
  logic pin_q;
  logic flag_a_q;
  logic flag_p_q;
  logic [5:0] div_q;
  logic fh_prev_q;
  logic ftbc_prev_q;
  logic ext_prev_q;
  logic [3:0] hdiv_q;
  logic [1:0] hdiv64_q;

  logic counter_on;
  logic on_rise;
  logic tick;
  logic [CTM_CNT_W-1:0] cmpa_val;
  logic [CTM_P_W-1:0] cmpp_val;
  logic match_a;
  logic match_p;
  logic clear_cnt;
  logic set_a;
  logic set_p;
  logic pwm_active;
  logic pwm_level;
  logic out_d;
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  logic clr_a;
  logic clr_p;

  assign counter_on = ctrl0_q[CTM_C0_ON];
  assign on_rise = counter_on && !on_prev_q;
  assign cmpa_val = {cmpa_hi_q, cmpa_lo_q};
  assign cmpp_val = ctrl0_q[CTM_P_W-1:0];
  // Matches are taken as the counter steps onto a compare value, so a clear there gives a
  // period of exactly that many counts, in line with the 1024 counts of a plain wrap.
  assign cnt_nx = cnt_q + 10'h001;

  // Turns a 3-bit P code into a count; code zero means full range.
  function automatic logic [CTM_CNT_W:0] p_to_count(input logic [CTM_P_W-1:0] code);
    if (code == CTM_P_ZERO)
    begin
      return {1'b1, {CTM_CNT_W{1'b0}}};
    end
    return {1'b0, code, {(CTM_CNT_W-CTM_P_W){1'b0}}};
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // APB decode. The slave answers in the access cycle, so there are no wait states.
  assign wr_en = APB_REQ.psel && APB_REQ.penable && APB_REQ.pwrite;
  assign rd_en = APB_REQ.psel && !APB_REQ.penable && !APB_REQ.pwrite;

  always_comb
  begin
    case (APB_REQ.paddr)
      CTM_OFS_CTRL0, CTM_OFS_CTRL1, CTM_OFS_CNT_LO, CTM_OFS_CNT_HI,
      CTM_OFS_CMPA_LO, CTM_OFS_CMPA_HI, CTM_OFS_FLAGS: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  assign clr_a = wr_en && addr_ok && (APB_REQ.paddr == CTM_OFS_FLAGS) &&
                 APB_REQ.pwdata[CTM_FLAG_A];
  assign clr_p = wr_en && addr_ok && (APB_REQ.paddr == CTM_OFS_FLAGS) &&
                 APB_REQ.pwdata[CTM_FLAG_P];

  // Register writes. Mode and pin action should only change while stopped.
  always_ff @(posedge MCLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      ctrl0_q <= CTM_RST_BYTE;
      ctrl1_q <= CTM_RST_BYTE;
      cmpa_lo_q <= CTM_RST_BYTE;
      cmpa_hi_q <= 2'h0;
    end
    else if (wr_en)
    begin
      case (APB_REQ.paddr)
        CTM_OFS_CTRL0: ctrl0_q <= APB_REQ.pwdata[7:0];
        CTM_OFS_CTRL1: ctrl1_q <= APB_REQ.pwdata[7:0];
        CTM_OFS_CMPA_LO: cmpa_lo_q <= APB_REQ.pwdata[7:0];
        CTM_OFS_CMPA_HI: cmpa_hi_q <= APB_REQ.pwdata[1:0];
        default: ;
      endcase
    end
  end

  // Read data is registered in setup so it is stable in the access cycle.
  always_ff @(posedge MCLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      PRDATA <= 32'h0000_0000;
    end
    else if (rd_en)
    begin
      case (APB_REQ.paddr)
        CTM_OFS_CTRL0: PRDATA <= {24'h000000, ctrl0_q};
        CTM_OFS_CTRL1: PRDATA <= {24'h000000, ctrl1_q};
        CTM_OFS_CNT_LO: PRDATA <= {24'h000000, cnt_q[7:0]};
        CTM_OFS_CNT_HI: PRDATA <= {30'h00000000, cnt_q[9:8]};
        CTM_OFS_CMPA_LO: PRDATA <= {24'h000000, cmpa_lo_q};
        CTM_OFS_CMPA_HI: PRDATA <= {30'h00000000, cmpa_hi_q};
        CTM_OFS_FLAGS: PRDATA <= {30'h00000000, flag_p_q, flag_a_q};
        default: PRDATA <= 32'h0000_0000;
      endcase
    end
  end

  // Ready high from the first clock after reset; unmapped addresses get an error in the access phase.
  always_ff @(posedge MCLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
    end
    else
    begin
      PREADY <= 1'b1;
      PSLVERR <= APB_REQ.psel && !APB_REQ.penable && !addr_ok;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Count clock selection. The fH taps divide the sampled fH edge rate.
  always_ff @(posedge MCLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      div_q <= 6'h00;
      fh_prev_q <= 1'b0;
      ftbc_prev_q <= 1'b0;
      ext_prev_q <= 1'b0;
      hdiv_q <= 4'h0;
      hdiv64_q <= 2'h0;
    end
    else
    begin
      div_q <= div_q + 6'h01;
      fh_prev_q <= CLK_IN.fh;
      ftbc_prev_q <= CLK_IN.ftbc;
      ext_prev_q <= CLK_IN.ext_clk;
      if (CLK_IN.fh && !fh_prev_q)
      begin
        hdiv_q <= hdiv_q + 4'h1;
        if (hdiv_q == 4'(CTM_DIV_H16 - 1))
        begin
          hdiv64_q <= hdiv64_q + 2'h1;
        end
      end
    end
  end

  // One-cycle count enable from the chosen source.
  always_comb
  begin
    case (ctm_clk_sel_type'(ctrl0_q[CTM_C0_CK_LSB +: 3]))
      CTM_CK_SYS4: tick = (div_q[1:0] == 2'(CTM_DIV_SYS4 - 1));
      CTM_CK_SYS: tick = 1'b1;
      CTM_CK_H16: tick = CLK_IN.fh && !fh_prev_q && (hdiv_q == 4'(CTM_DIV_H16 - 1));
      CTM_CK_H64: tick = CLK_IN.fh && !fh_prev_q && (hdiv_q == 4'(CTM_DIV_H16 - 1)) &&
                         (hdiv64_q == 2'(CTM_DIV_H64 / CTM_DIV_H16 - 1));
      CTM_CK_TBC0, CTM_CK_TBC1: tick = CLK_IN.ftbc && !ftbc_prev_q;
      CTM_CK_EXTR: tick = CLK_IN.ext_clk && !ext_prev_q;
      CTM_CK_EXTF: tick = !CLK_IN.ext_clk && ext_prev_q;
      default: tick = 1'b0;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // Comparators and clear selection.
  always_comb
  begin
    match_p = tick && (cnt_nx[CTM_CNT_W-1 -: CTM_P_W] == cmpp_val) &&
              (cmpp_val != CTM_P_ZERO) && (cnt_nx[CTM_CNT_W-CTM_P_W-1:0] == '0);
    match_a = tick && (cnt_nx == cmpa_val) && (cmpa_val != '0);
    set_a = 1'b0;
    set_p = 1'b0;
    clear_cnt = 1'b0;
    if (ctrl1_q.op_mode == CTM_MODE_PWM)
    begin
      // Period comes from one comparator, duty from the other.
      set_a = match_a;
      set_p = match_p;
      if (ctrl1_q.period_duty_swap)
      begin
        clear_cnt = match_a || (tick && cnt_q == CTM_CNT_MAX);
      end
      else
      begin
        clear_cnt = match_p || (tick && cnt_q == CTM_CNT_MAX);
      end
    end
    else if (ctrl1_q.op_mode != CTM_MODE_UNDEF)
    begin
      set_a = match_a;
      if (ctrl1_q.clear_source_sel)
      begin
        clear_cnt = match_a || (tick && cnt_q == CTM_CNT_MAX);
      end
      else
      begin
        set_p = match_p;
        clear_cnt = match_p || (tick && cnt_q == CTM_CNT_MAX);
      end
    end
  end

  // Counter: enable rise zeroes, disable holds.
  always_ff @(posedge MCLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      cnt_q <= '0;
      on_prev_q <= 1'b0;
    end
    else
    begin
      on_prev_q <= counter_on;
      if (on_rise)
      begin
        cnt_q <= '0;
      end
      else if (counter_on && tick)
      begin
        cnt_q <= clear_cnt ? '0 : cnt_nx;
      end
    end
  end

  // Sticky flags; a set in the clearing cycle wins.
  always_ff @(posedge MCLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      flag_a_q <= 1'b0;
      flag_p_q <= 1'b0;
    end
    else
    begin
      flag_a_q <= (counter_on && set_a) || (flag_a_q && !clr_a);
      flag_p_q <= (counter_on && set_p) || (flag_p_q && !clr_p);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // PWM level: active from period start until the duty count is reached.
  always_comb
  begin
    if (ctrl1_q.period_duty_swap)
    begin
      pwm_active = {1'b0, cnt_q} < p_to_count(cmpp_val) ||
                   p_to_count(cmpp_val) >= {1'b0, cmpa_val};
    end
    else
    begin
      pwm_active = {1'b0, cnt_q} < {1'b0, cmpa_val} ||
                   {1'b0, cmpa_val} >= p_to_count(cmpp_val);
    end
    case (ctrl1_q.pin_action)
      2'h0: pwm_level = !ctrl1_q.pin_initial_level;
      2'h1: pwm_level = ctrl1_q.pin_initial_level;
      2'h2: pwm_level = pwm_active ? ctrl1_q.pin_initial_level : !ctrl1_q.pin_initial_level;
      default: pwm_level = !ctrl1_q.pin_initial_level;
    endcase
  end

  // Compare-mode pin state, loaded with the initial level at enable rise, else moved only by A-match flag events.
  always_ff @(posedge MCLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      pin_q <= 1'b0;
    end
    else if (on_rise)
    begin
      pin_q <= ctrl1_q.pin_initial_level;
    end
    else if (counter_on && set_a && ctrl1_q.op_mode == CTM_MODE_CMP)
    begin
      case (ctrl1_q.pin_action)
        2'h1: pin_q <= 1'b0;
        2'h2: pin_q <= 1'b1;
        2'h3: pin_q <= !pin_q;
        default: pin_q <= pin_q;
      endcase
    end
  end

  // Output pin; timer/counter mode parks it low since the pin is unused.
  always_comb
  begin
    case (ctrl1_q.op_mode)
      CTM_MODE_CMP: out_d = pin_q ^ ctrl1_q.pin_invert;
      CTM_MODE_PWM: out_d = pwm_level ^ ctrl1_q.pin_invert;
      default: out_d = 1'b0;
    endcase
  end

  always_ff @(posedge MCLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      TMR_OUT <= 1'b0;
      MATCH_A_FLAG <= 1'b0;
      MATCH_P_FLAG <= 1'b0;
    end
    else
    begin
      TMR_OUT <= out_d;
      MATCH_A_FLAG <= flag_a_q;
      MATCH_P_FLAG <= flag_p_q;
    end
  end

endmodule // ctm_timer

`default_nettype wire

// *** test/ctm_timer_properties.sv ***
// Checker for the compact timer: bus answers, flag clearing and pin start level.
// Assumes it is bound to ctm_timer and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none

module ctm_timer_properties
  import ctm_pkg::*;
(
  // Clock, reset and bus.
  input wire logic MCLK,
  input wire logic RSTN,
  input wire ctm_pkg::ctm_apb_req_type APB_REQ,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  // Count clocks, pin and flags.
  input wire ctm_pkg::ctm_clk_in_type CLK_IN,
  input wire logic TMR_OUT,
  input wire logic MATCH_A_FLAG,
  input wire logic MATCH_P_FLAG
);
  import ctm_pkg::*;

  logic acc;
  logic wr;
  logic map;
  logic [7:0] c0_q;
  logic [7:0] c1_q;
  // Access-phase decode of the bus.
  assign acc = APB_REQ.psel && APB_REQ.penable;
  assign wr = acc && APB_REQ.pwrite;
  assign map = APB_REQ.paddr <= CTM_OFS_FLAGS && APB_REQ.paddr[1:0] == 2'h0;
  // Shadow of the control bytes, so the checker knows the mode without peeking inside.
  always_ff @(posedge MCLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      c0_q <= CTM_RST_BYTE;
      c1_q <= CTM_RST_BYTE;
    end
    else if (wr)
    begin
      if (APB_REQ.paddr == CTM_OFS_CTRL0) c0_q <= APB_REQ.pwdata[7:0];
      if (APB_REQ.paddr == CTM_OFS_CTRL1) c1_q <= APB_REQ.pwdata[7:0];
    end
  end
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!RSTN);
  sequence s_clr_a;
    $past(wr && APB_REQ.paddr == CTM_OFS_FLAGS && APB_REQ.pwdata[CTM_FLAG_A], 2);
  endsequence
  sequence s_clr_p;
    $past(wr && APB_REQ.paddr == CTM_OFS_FLAGS && APB_REQ.pwdata[CTM_FLAG_P], 2);
  endsequence
  sequence s_on_cmp;
    $rose(c0_q[CTM_C0_ON]) && c1_q[7:6] == 2'h0;
  endsequence
  a_ready_out_reset: assert property ($past(RSTN) |-> PREADY)
    else $error("ready low after reset");
  a_unmapped_err: assert property (acc && !map |->
    PSLVERR && (APB_REQ.pwrite || PRDATA == 32'h0))
    else $error("unmapped access not refused");
  a_mapped_ok: assert property (acc && map |-> !PSLVERR)
    else $error("mapped access refused");
  a_high_byte_zero: assert property (acc && !APB_REQ.pwrite && APB_REQ.paddr == CTM_OFS_CMPA_HI
    |-> PRDATA[31:2] == 30'h0)
    else $error("compare A high byte upper bits set");
  a_flag_a_sticky: assert property ($fell(MATCH_A_FLAG) |-> s_clr_a)
    else $error("A flag fell without clear");
  a_flag_p_sticky: assert property ($fell(MATCH_P_FLAG) |-> s_clr_p)
    else $error("P flag fell without clear");
  a_no_p_flag: assert property ($rose(MATCH_P_FLAG)
    |-> !($past(c1_q[0], 2) && $past(c1_q[7:6], 2) != 2'h2))
    else $error("P flag raised with A clearing");
  a_pin_init_level: assert property (s_on_cmp |-> ##[1:3] TMR_OUT == (c1_q[3] ^ c1_q[2]))
    else $error("pin not at initial level after enable");
endmodule // ctm_timer_properties

bind ctm_timer ctm_timer_properties u_props (.MCLK(MCLK), .RSTN(RSTN), .APB_REQ(APB_REQ),
  .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .CLK_IN(CLK_IN), .TMR_OUT(TMR_OUT),
  .MATCH_A_FLAG(MATCH_A_FLAG), .MATCH_P_FLAG(MATCH_P_FLAG));
`default_nettype wire

// *** test/ctm_pin_load.sv ***
// Load on the timer output pin: measures the last period and its high time.
// Assumes the pin is a registered level, sampled on the system clock.
`timescale 1ns/1ps
`default_nettype none

module ctm_pin_load
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Observed pin and its measurements.
  input wire logic pin,
  output logic [11:0] per_len,
  output logic [11:0] hi_len
);
  logic pin_q;
  logic [11:0] cnt_q;
  logic [11:0] acc_q;
  // A rising edge closes a period; counts wrap, so periods must stay under 4096 cycles.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_q <= 1'b0;
      cnt_q <= 12'h000;
      acc_q <= 12'h000;
      per_len <= 12'h000;
      hi_len <= 12'h000;
    end
    else
    begin
      pin_q <= pin;
      if (pin && !pin_q)
      begin
        per_len <= cnt_q;
        hi_len <= acc_q;
        cnt_q <= 12'h001;
        acc_q <= 12'h001;
      end
      else
      begin
        cnt_q <= cnt_q + 12'h001;
        acc_q <= acc_q + {11'h000, pin};
      end
    end
  end
endmodule // ctm_pin_load
`default_nettype wire

// *** test/test_ctm_timer.sv ***
// Testbench of the compact timer: registers, compare, timer and PWM modes.
// Assumes the pin load model and the bound checker are compiled alongside.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin errors++; \
  $display("MISMATCH %s exp %h got %h", nm, e, g); end end

module test_ctm_timer;
  import ctm_pkg::*;
  logic mclk, rstn, pready, pslverr, pin, fa, fp, err;
  ctm_apb_req_type req;
  ctm_clk_in_type ck;
  logic [31:0] prdata, q;
  logic [11:0] per, hi;
  int errors = 0;
  int total_checks = 0;
  ctm_timer dut (.MCLK(mclk), .RSTN(rstn), .APB_REQ(req), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .CLK_IN(ck), .TMR_OUT(pin), .MATCH_A_FLAG(fa), .MATCH_P_FLAG(fp));
  ctm_pin_load load (.clk(mclk), .rst_n(rstn), .pin(pin), .per_len(per), .hi_len(hi));
  // Free-running 125 MHz clock.
  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  task automatic end_of_test;
    if (errors == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // One bus transfer; the request stands until ready is seen at an edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    req <= '{1'b1, 1'b0, w, a, {24'h0, d}};
    @(posedge mclk);
    req.penable <= 1'b1;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (pready !== 1'b1 && n < 100);
    q = prdata;
    err = pslverr;
    req <= '0;
    if (n >= 100)
    begin
      errors++;
      end_of_test();
    end
  endtask
  task automatic wait_a;
    int n;
    n = 0;
    while (fa !== 1'b1 && n < 3000)
    begin
      @(posedge mclk);
      n++;
    end
    if (n >= 3000)
    begin
      errors++;
      end_of_test();
    end
  endtask
  // Reconfigure while stopped, then enable; the enable rise restarts the counter.
  task automatic run(input logic [7:0] c1, input logic [9:0] ca, input logic [2:0] code);
    apb(1'b1, CTM_OFS_CTRL0, {1'b0, CTM_CK_SYS, 4'h0});
    apb(1'b1, CTM_OFS_FLAGS, 8'h03);
    apb(1'b1, CTM_OFS_CTRL1, c1);
    apb(1'b1, CTM_OFS_CMPA_LO, ca[7:0]);
    apb(1'b1, CTM_OFS_CMPA_HI, {6'h00, ca[9:8]});
    apb(1'b1, CTM_OFS_CTRL0, {1'b0, CTM_CK_SYS, 1'b1, code});
  endtask
  task automatic t_regs;
    apb(1'b0, CTM_OFS_CMPA_HI, 8'h00);
    `CHK("cmpa hi reset", 32'h0, q)
    apb(1'b1, CTM_OFS_CMPA_HI, 8'hFF);
    apb(1'b0, CTM_OFS_CMPA_HI, 8'h00);
    `CHK("cmpa hi readback", 32'h3, q)
    apb(1'b0, 8'h40, 8'h00);
    `CHK("unmapped err", 1'b1, err)
  endtask
  task automatic t_cmp;
    run(8'h39, 10'h12C, 3'h1);
    repeat (4) @(posedge mclk);
    `CHK("pin start", 1'b1, pin)
    wait_a();
    repeat (3) @(posedge mclk);
    `CHK("pin toggled", 1'b0, pin)
    `CHK("p flag", 1'b0, fp)
    apb(1'b0, CTM_OFS_FLAGS, 8'h00);
    `CHK("flags a only", 32'h1, q)
    apb(1'b1, CTM_OFS_FLAGS, 8'h01);
    apb(1'b0, CTM_OFS_FLAGS, 8'h00);
    `CHK("flags cleared", 32'h0, q)
  endtask
  task automatic t_tmr;
    run(8'hC0, 10'h064, 3'h1);
    repeat (300) @(posedge mclk);
    apb(1'b0, CTM_OFS_FLAGS, 8'h00);
    `CHK("both flags", 32'h3, q)
    `CHK("timer pin", 1'b0, pin)
  endtask
  // One rising and one falling edge on the external count pin, a cycle each.
  task automatic ext_pulse;
    @(posedge mclk);
    ck.ext_clk <= 1'b1;
    @(posedge mclk);
    ck.ext_clk <= 1'b0;
  endtask
  // Compare-A zero gives no A flag; external rising edges count; stopping holds the count.
  task automatic t_clk;
    run(8'hC1, 10'h000, 3'h0);
    repeat (1100) @(posedge mclk);
    apb(1'b0, CTM_OFS_FLAGS, 8'h00);
    `CHK("no a flag at zero", 32'h0, q)
    apb(1'b1, CTM_OFS_CTRL0, 8'h00);
    apb(1'b1, CTM_OFS_CTRL0, {1'b0, CTM_CK_EXTR, 1'b1, 3'h0});
    repeat (5) ext_pulse();
    apb(1'b0, CTM_OFS_CNT_LO, 8'h00);
    `CHK("ext rise count", 32'h5, q)
    apb(1'b1, CTM_OFS_CTRL0, {1'b0, CTM_CK_EXTR, 1'b0, 3'h0});
    repeat (3) ext_pulse();
    apb(1'b0, CTM_OFS_CNT_LO, 8'h00);
    `CHK("count held off", 32'h5, q)
  endtask
  task automatic t_pwm;
    int n;
    n = 0;
    run(8'hA9, 10'h020, 3'h1);
    repeat (600) @(posedge mclk);
    `CHK("pwm period", 12'd128, per)
    `CHK("pwm duty", 12'd32, hi)
    run(8'hAE, 10'h12C, 3'h1);
    repeat (1200) @(posedge mclk);
    `CHK("swap low time", 12'd128, per - hi)
    `CHK("swap period", 12'd300, per)
    run(8'hA8, 10'h0C8, 3'h1);
    repeat (4) @(posedge mclk);
    repeat (400)
    begin
      @(posedge mclk);
      if (pin !== 1'b1) n++;
    end
    `CHK("full duty lows", 0, n)
    run(8'h88, 10'h020, 3'h1);
    wait_a();
    `CHK("forced inactive", 1'b0, pin)
    repeat (200) @(posedge mclk);
    apb(1'b0, CTM_OFS_FLAGS, 8'h00);
    `CHK("pwm both flags", 32'h3, q)
    `CHK("forced still", 1'b0, pin)
  endtask
  // Reset for four cycles, then the scenarios in turn.
  initial
  begin
    rstn = 1'b0;
    req = '0;
    ck = '0;
    repeat (4) @(posedge mclk);
    rstn <= 1'b1;
    t_regs();
    t_cmp();
    t_tmr();
    t_clk();
    t_pwm();
    end_of_test();
  end
endmodule // test_ctm_timer
`default_nettype wire
